// >>> dv/dcso_mem_model.sv
// ==========
// Main-memory responder for the cache controller
// Assumes request held until one-cycle ack; delay set by the bench
module dcso_mem_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       mem_req_i,
   input  wire logic [4:0] delay_i,
   output logic            mem_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] wait_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r    <= 5'h00;
         mem_ack_o <= 1'b0;
      end else begin
         mem_ack_o <= mem_req_i && !mem_ack_o && wait_r >= delay_i;
         wait_r    <= (mem_req_i && !mem_ack_o) ? wait_r + 5'h01 : 5'h00;
      end
   end
endmodule

// >>> dv/dcso_top_test.sv
// ==========
// Self-checking bench of the cache special-operation controller
// Assumes dcso_top and dcso_mem_model compiled before it
module dcso_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dcso_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, op_v = 1'b0, st_m = 1'b0, ld_v = 1'b0, sp_r = 1'b0, sp_d = 1'b0;
   logic        ack, res_v, stall, acc, mreq, mwr, ldv_o, m_w;
   logic [2:0]  slot = 3'h5;
   logic [1:0]  miss = 2'h0;
   logic [4:0]  dly = 5'h01;
   logic [8:0]  ofs = 9'h000;
   logic [31:0] base = 32'h0, idx = 32'h0, st_a = 32'h0, ld_d = 32'h0, rnd = 32'h0000ee60, cyc = 32'h0;
   logic [31:0] res, maddr, ldd_o, m_a, cba = 32'h0;
   logic        cbv = 1'b0;
   dcso_op_t    op_c = DCSO_OP_NONE;
   logic [31:0] rq[$];
   logic [63:0] lq[$];
   int          n_mismatch = 0, checked = 0, n_st, m_n, i;

   always #2 clk = ~clk;

   dcso_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .op_valid_i(op_v), .op_slot_i(slot), .op_code_i(op_c),
      .base_operand_i(base), .index_operand_i(idx), .offset_i(ofs), .dram_base_i(32'h1000_0000),
      .dram_cacheable_limit_i(32'h1100_0000), .misses_outstanding_i(miss), .st_mark_i(st_m), .st_addr_i(st_a),
      .ld_valid_i(ld_v), .ld_data_i(ld_d), .special_req_i(sp_r), .special_done_i(sp_d), .cbinv_i(cbv),
      .cbinv_addr_i(cba), .mem_ack_i(ack), .result_valid_o(res_v), .result_o(res), .cache_stall_o(stall),
      .access_stall_o(acc), .mem_req_o(mreq), .mem_wr_o(mwr), .mem_addr_o(maddr), .ld_valid_o(ldv_o),
      .ld_data_o(ldd_o));
   dcso_mem_model mem (.clk_i(clk), .rst_n_i(rst_n), .mem_req_i(mreq), .delay_i(dly), .mem_ack_o(ack));

   task automatic conclude;
      if (rq.size() != 0 || lq.size() != 0) n_mismatch++;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   // Issue one op, hold it while stalled, count stall cycles
   task automatic op(input dcso_op_t c, input logic [31:0] b, input logic [31:0] x, input logic [8:0] o);
      @(posedge clk);
      op_c <= c;
      base <= b;
      idx  <= x;
      ofs  <= o;
      op_v <= 1'b1;
      m_n = 0;
      n_st = 0;
      @(posedge clk);
      #1;
      while (stall === 1'b1 && n_st < 60) begin
         n_st++;
         @(posedge clk);
         #1;
      end
      op_v <= 1'b0;
      if (n_st == 60) begin
         n_mismatch++;
         conclude();
      end
   endtask

   // Result watcher: memory handshakes, read results, load results
   always @(posedge clk) begin
      cyc <= cyc + 32'h1;
      if (mreq === 1'b1 && ack === 1'b1) begin
         m_n++;
         m_w = mwr;
         m_a = maddr;
      end
      if (res_v === 1'b1) chk({32'h0, res}, {32'h0, rq.pop_front()});
      if (ldv_o === 1'b1) chk({cyc, ldd_o}, lq.pop_front());
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 100 && stall !== 1'b0; i++) @(posedge clk);
      if (i == 100) begin
         n_mismatch++;
         conclude();
      end
      for (i = 0; i < 12; i++) begin
         @(posedge clk);
         rnd = xs(rnd);
         ld_v <= rnd[0];
         ld_d <= rnd;
         if (rnd[0]) lq.push_back({cyc + 32'h4, rnd});
      end
      @(posedge clk);
      ld_v <= 1'b0;
      slot <= 3'h4;
      op(DCSO_OP_ALLOC_D, 32'h1000_0240, 32'h0, 9'h000);
      chk(n_st, 0);
      slot <= 3'h5;
      op(DCSO_OP_ALLOC_D, 32'h1000_0150, 32'h0, 9'h1f0);
      chk(n_st, 3);
      chk(m_n, 0);
      @(posedge clk);
      st_m <= 1'b1;
      st_a <= 32'h1000_0144;
      @(posedge clk);
      st_m <= 1'b0;
      rq.push_back(32'h8002_0000);
      op(DCSO_OP_RDTAG, 32'hfffc_0150, 32'h0, 9'h1f0);
      chk(n_st, 0);
      rq.push_back(32'h0000_0101);
      op(DCSO_OP_RDSTATUS, 32'hffff_f940, 32'h0, 9'h000);
      chk(n_st, 1);
      for (i = 1; i < 8; i++) begin
         op(i[0] ? DCSO_OP_ALLOC_R : DCSO_OP_ALLOC_X, 32'h1000_0140, i[0] ? i << 11 : i << 9, 9'h000);
         chk(n_st, 3);
         rq.push_back(32'h8002_0000 + i);
         op(DCSO_OP_RDTAG, 32'h0000_0140 + (i << 11), 32'h0, 9'h000);
      end
      dly <= 5'h14;
      fork
         op(DCSO_OP_ALLOC_D, 32'h1000_4140, 32'h0, 9'h000);
         begin
            // Copyback of the victim block while its writeback is pending
            repeat (4) @(posedge clk);
            sp_r <= 1'b1;
            cbv  <= 1'b1;
            cba  <= 32'h1000_017c;
            @(posedge clk);
            sp_r <= 1'b0;
            sp_d <= 1'b1;
            repeat (8) @(posedge clk);
            #1;
            chk(acc, 1);
            for (i = 0; i < 40 && mreq === 1'b1; i++) begin
               @(posedge clk);
               #1;
            end
            if (i == 40) begin
               n_mismatch++;
               conclude();
            end
            @(posedge clk);
            #1;
            chk(acc, 0);
            sp_d <= 1'b0;
            cbv  <= 1'b0;
         end
      join
      chk(n_st >= 11, 1);
      chk({m_n, m_w, m_a}, {32'h1, 1'b1, 32'h1000_0140});
      dly <= 5'h01;
      op(DCSO_OP_PREF_H, 32'h1001_0000, 32'h100, 9'h000);
      chk(n_st, 3);
      chk({m_n, m_w, m_a}, {32'h1, 1'b0, 32'h1001_0200});
      op(DCSO_OP_PREF_W, 32'h1001_0100, 32'h40, 9'h000);
      chk({n_st, m_n}, {32'h3, 32'h0});
      miss <= 2'h2;
      op(DCSO_OP_PREF_D, 32'h1002_0000, 32'h0, 9'h000);
      chk({n_st, m_n}, 0);
      miss <= 2'h0;
      op(DCSO_OP_ALLOC_X, 32'h2000_0000, 32'h1, 9'h000);
      chk(n_st, 0);
      op(DCSO_OP_PREF_R, 32'h2000_0000, 32'h40, 9'h000);
      chk({n_st, m_n}, 0);
      @(posedge clk);
      sp_r <= 1'b1;
      @(posedge clk);
      sp_r <= 1'b0;
      repeat (3) @(posedge clk);
      sp_d <= 1'b1;
      #1;
      chk(acc, 1);
      @(posedge clk);
      sp_d <= 1'b0;
      #1;
      chk(acc, 0);
      repeat (10) @(posedge clk);
      conclude();
   end
endmodule

// >>> hw/dcso_consts.svh
// =====================================================================
// Constants of the data-cache special-operation controller
// =====================================================================
// Assumes a 64-byte block, 32 sets, 8 ways, one core clock
// What this block does
// - Target is base plus signed offset, or base plus scaled index
// - Tag read: set bits 10..6, way 13..11
// - Tag read returns tag and valid bit
// - Tag read never stalls the core
// - Status read returns dirty and LRU bits
// - Status read stalls exactly one cycle
// - Allocate claims block valid, no fetch
// - Allocate outside cacheable aperture discarded
// - Allocate: three stalls, dirty victim eleven plus
// - Allocate addresses: offset, index, four times index
// - Prefetch fills block while core runs
// - Prefetch outside cacheable aperture discarded
// - Prefetch dropped with two misses outstanding
// - Prefetch: three stalls, dirty eleven plus
// - Prefetch addresses: offset, index, two, four
// - Operations take effect in issue order
// - Copyback waits for pending same-block writeback
// - Special accesses stall until completion
// - Loads have three-cycle latency; store marks set dirty next edge unless an allocate or prefetch acts that cycle
// - Special operations run on slot five
`ifndef DCSO_CONSTS_SVH
`define DCSO_CONSTS_SVH

`define DCSO_SET_LO       6
`define DCSO_SET_HI       10
`define DCSO_WAY_LO       11
`define DCSO_WAY_HI       13
`define DCSO_TAG_LO       11
`define DCSO_TAG_HI       31
`define DCSO_BLK_MASK     32'hffffffc0
`define DCSO_BLK_ZERO     6'h00
`define DCSO_SPECIAL_SLOT 3'h5
`define DCSO_STALL_STATUS 4'h1
`define DCSO_STALL_ALLOC  4'h3
`define DCSO_STALL_WB     4'hb
`define DCSO_LD_LAT       3
`define DCSO_MAX_MISSES   2'h2
`define DCSO_RES_VALID    31
`define DCSO_RES_LRU_LO   8
`define DCSO_LRU_RESET    10'h000

`endif

// >>> hw/dcso_pkg.sv
// =====================================================================
// Types of the data-cache special-operation controller
// =====================================================================
// Shared by the controller and its bench
package dcso_pkg;

   typedef enum logic [3:0] {
      DCSO_OP_NONE     = 4'h0,
      DCSO_OP_RDTAG    = 4'h1,
      DCSO_OP_RDSTATUS = 4'h2,
      DCSO_OP_ALLOC_D  = 4'h3,
      DCSO_OP_ALLOC_R  = 4'h4,
      DCSO_OP_ALLOC_X  = 4'h5,
      DCSO_OP_PREF_D   = 4'h6,
      DCSO_OP_PREF_R   = 4'h7,
      DCSO_OP_PREF_H   = 4'h8,
      DCSO_OP_PREF_W   = 4'h9
   } dcso_op_t;

   typedef enum logic [3:0] {
      DCSO_ST_INIT  = 4'b0001,
      DCSO_ST_IDLE  = 4'b0010,
      DCSO_ST_STALL = 4'b0100,
      DCSO_ST_WB    = 4'b1000
   } dcso_state_t;

endpackage

// >>> hw/dcso_top.sv
// =====================================================================
// Data-cache special operations: tag/status read, allocate, prefetch
// =====================================================================
// Core issues on the slot-five port and holds an op while stalled;
// memory answers each request with a one-cycle ack.
`include "dcso_consts.svh"

module dcso_top #(
   parameter int SETS = 32,
   parameter int WAYS = 8
) (
   input  wire logic              core_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              op_valid_i,
   input  wire logic [2:0]        op_slot_i,
   input  wire dcso_pkg::dcso_op_t op_code_i,
   input  wire logic [31:0]       base_operand_i,
   input  wire logic [31:0]       index_operand_i,
   input  wire logic [8:0]        offset_i,
   input  wire logic [31:0]       dram_base_i,
   input  wire logic [31:0]       dram_cacheable_limit_i,
   input  wire logic [1:0]        misses_outstanding_i,
   input  wire logic              st_mark_i,
   input  wire logic [31:0]       st_addr_i,
   input  wire logic              ld_valid_i,
   input  wire logic [31:0]       ld_data_i,
   input  wire logic              special_req_i,
   input  wire logic              special_done_i,
   input  wire logic              cbinv_i,
   input  wire logic [31:0]       cbinv_addr_i,
   input  wire logic              mem_ack_i,
   output logic                   result_valid_o,
   output logic [31:0]            result_o,
   output logic                   cache_stall_o,
   output logic                   access_stall_o,
   output logic                   mem_req_o,
   output logic                   mem_wr_o,
   output logic [31:0]            mem_addr_o,
   output logic                   ld_valid_o,
   output logic [31:0]            ld_data_o
);
   import dcso_pkg::*;

   // ==================================================================
   // Storage
   // ==================================================================
   logic [20:0]       tag_mem [0:SETS*WAYS-1];
   logic [WAYS-1:0]   valid_r [0:SETS-1];
   logic [WAYS-1:0]   dirty_r [0:SETS-1];
   logic [9:0]        lru_r   [0:SETS-1];

   dcso_state_t       state_r;
   logic [3:0]        cnt_r;
   logic [4:0]        init_set_r;
   logic              wb_done_r;
   logic              fill_pend_r;
   logic [31:0]       fill_addr_r;
   logic [2:0]        fill_way_r;
   logic              held_r;
   dcso_op_t          held_op_r;
   logic [31:0]       held_addr_r;
   logic [31:0]       wb_addr_r;
   logic              cur_pref_r;
   logic [31:0]       ld_data_pipe [0:`DCSO_LD_LAT-1];
   logic [`DCSO_LD_LAT-1:0] ld_valid_pipe;

   // ==================================================================
   // Address helpers
   // ==================================================================
   function automatic logic [31:0] target_addr(input dcso_op_t op, input logic [31:0] b,
                                                input logic [31:0] x, input logic [8:0] ofs);
      logic [31:0] sum;
      sum = b + {{23{ofs[8]}}, ofs};
      case (op)
         DCSO_OP_ALLOC_R, DCSO_OP_PREF_R: sum = b + x;
         DCSO_OP_PREF_H:                  sum = b + {x[30:0], 1'b0};
         DCSO_OP_ALLOC_X, DCSO_OP_PREF_W: sum = b + {x[29:0], 2'b00};
         default: ;
      endcase
      return sum;
   endfunction

   function automatic logic [4:0] set_of(input logic [31:0] a);
      return a[`DCSO_SET_HI:`DCSO_SET_LO];
   endfunction

   function automatic logic [20:0] tag_of(input logic [31:0] a);
      return a[`DCSO_TAG_HI:`DCSO_TAG_LO];
   endfunction

   // ==================================================================
   // Operation decode
   // ==================================================================
   logic        go;
   dcso_op_t    eff_op;
   logic [31:0] eff_addr;
   logic [31:0] blk_addr;
   logic [4:0]  eff_set;
   logic        is_alloc;
   logic        is_pref;
   logic        cacheable;
   logic        hit;
   logic [2:0]  hit_way;
   logic [2:0]  vic_way;
   logic        vic_dirty;
   logic        pref_drop;
   logic [7:0]  blk_idx;

   always_comb begin
      if (held_r) begin
         eff_op   = held_op_r;
         eff_addr = held_addr_r;
      end else begin
         eff_op   = op_code_i;
         eff_addr = target_addr(op_code_i, base_operand_i, index_operand_i, offset_i);
      end
      blk_addr  = eff_addr & `DCSO_BLK_MASK;
      eff_set   = set_of(eff_addr);
      is_alloc  = (eff_op == DCSO_OP_ALLOC_D) || (eff_op == DCSO_OP_ALLOC_R) || (eff_op == DCSO_OP_ALLOC_X);
      is_pref   = (eff_op == DCSO_OP_PREF_D) || (eff_op == DCSO_OP_PREF_R) ||
                  (eff_op == DCSO_OP_PREF_H) || (eff_op == DCSO_OP_PREF_W);
      cacheable = (blk_addr >= dram_base_i) && (blk_addr < dram_cacheable_limit_i);
      hit       = 1'b0;
      hit_way   = 3'h0;
      for (int w = 0; w < WAYS; w++) begin
         if (valid_r[eff_set][w] && tag_mem[{eff_set, w[2:0]}] == tag_of(eff_addr)) begin
            hit     = 1'b1;
            hit_way = w[2:0];
         end
      end
      vic_way   = hit ? hit_way : lru_r[eff_set][2:0];
      vic_dirty = !hit && valid_r[eff_set][vic_way] && dirty_r[eff_set][vic_way];
      pref_drop = ({1'b0, misses_outstanding_i} + {2'b00, fill_pend_r}) >= {1'b0, `DCSO_MAX_MISSES};
      blk_idx   = {eff_set, vic_way};
      // Held ops retry once the memory port is free; reads never wait on a fill
      go = (state_r == DCSO_ST_IDLE) &&
           (held_r ? !fill_pend_r :
                     (op_valid_i && op_slot_i == `DCSO_SPECIAL_SLOT &&
                      !(fill_pend_r && (is_alloc || is_pref))));
   end

   wire mem_need = is_alloc || is_pref;
   wire hold_now = (state_r == DCSO_ST_IDLE) && !held_r && op_valid_i &&
                   op_slot_i == `DCSO_SPECIAL_SLOT && fill_pend_r && mem_need;
   wire act_alloc = go && is_alloc && cacheable;
   wire act_pref  = go && is_pref && cacheable && !pref_drop;

   // ==================================================================
   // Sequencer and processor stall
   // ==================================================================
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r       <= DCSO_ST_INIT;
         cnt_r         <= 4'h0;
         init_set_r    <= 5'h00;
         cache_stall_o <= 1'b1;
         held_r        <= 1'b0;
         held_op_r     <= DCSO_OP_NONE;
         held_addr_r   <= 32'h0;
      end else begin
         if (hold_now) begin
            held_r        <= 1'b1;
            held_op_r     <= op_code_i;
            held_addr_r   <= eff_addr;
            cache_stall_o <= 1'b1;
         end else if (go) begin
            held_r <= 1'b0;
         end
         case (state_r)
            DCSO_ST_INIT: begin
               init_set_r <= init_set_r + 5'h01;
               if (init_set_r == 5'h1f) begin
                  state_r       <= DCSO_ST_IDLE;
                  cache_stall_o <= 1'b0;
               end
            end
            DCSO_ST_IDLE: begin
               if (go) begin
                  cache_stall_o <= 1'b0;
                  if (eff_op == DCSO_OP_RDSTATUS) begin
                     state_r       <= DCSO_ST_STALL;
                     cnt_r         <= `DCSO_STALL_STATUS - 4'h1;
                     cache_stall_o <= 1'b1;
                  end else if ((act_alloc || act_pref) && vic_dirty) begin
                     state_r       <= DCSO_ST_WB;
                     cnt_r         <= `DCSO_STALL_WB - 4'h1;
                     cache_stall_o <= 1'b1;
                  end else if (act_alloc || (go && is_pref && cacheable && !pref_drop)) begin
                     state_r       <= DCSO_ST_STALL;
                     cnt_r         <= `DCSO_STALL_ALLOC - 4'h1;
                     cache_stall_o <= 1'b1;
                  end
               end
            end
            DCSO_ST_STALL: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h0) begin
                  state_r       <= DCSO_ST_IDLE;
                  cache_stall_o <= 1'b0;
               end
            end
            DCSO_ST_WB: begin
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (wb_done_r) begin
                  state_r       <= DCSO_ST_IDLE;
                  cache_stall_o <= 1'b0;
               end
            end
            default: begin
               state_r       <= DCSO_ST_IDLE;
               cache_stall_o <= 1'b0;
            end
         endcase
      end
   end

   // ==================================================================
   // Memory port: writeback then optional fill
   // ==================================================================
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_req_o   <= 1'b0;
         mem_wr_o    <= 1'b0;
         mem_addr_o  <= 32'h0;
         wb_done_r   <= 1'b0;
         wb_addr_r   <= 32'h0;
         fill_pend_r <= 1'b0;
         fill_addr_r <= 32'h0;
         fill_way_r  <= 3'h0;
         cur_pref_r  <= 1'b0;
      end else begin
         if (act_alloc || act_pref) begin
            cur_pref_r <= act_pref;
            fill_addr_r <= blk_addr;
            fill_way_r  <= vic_way;
            wb_done_r   <= 1'b0;
            if (vic_dirty) begin
               mem_req_o  <= 1'b1;
               mem_wr_o   <= 1'b1;
               mem_addr_o <= {tag_mem[blk_idx], eff_set, `DCSO_BLK_ZERO};
               wb_addr_r  <= {tag_mem[blk_idx], eff_set, `DCSO_BLK_ZERO};
            end else if (act_pref && !hit) begin
               mem_req_o   <= 1'b1;
               mem_wr_o    <= 1'b0;
               mem_addr_o  <= blk_addr;
               fill_pend_r <= 1'b1;
            end
         end else if (mem_req_o && mem_ack_i) begin
            if (mem_wr_o) begin
               wb_done_r <= 1'b1;
               if (cur_pref_r) begin
                  mem_wr_o    <= 1'b0;
                  mem_addr_o  <= fill_addr_r;
                  fill_pend_r <= 1'b1;
               end else begin
                  mem_req_o <= 1'b0;
               end
            end else begin
               mem_req_o   <= 1'b0;
               fill_pend_r <= 1'b0;
            end
         end
      end
   end

   // ==================================================================
   // Tags, valid, dirty and replacement state
   // ==================================================================
   always_ff @(posedge core_clk_i) begin
      if (state_r == DCSO_ST_INIT) begin
         valid_r[init_set_r] <= '0;
         dirty_r[init_set_r] <= '0;
         lru_r[init_set_r]   <= `DCSO_LRU_RESET;
      end else begin
         if (st_mark_i && !(act_alloc || act_pref)) begin
            for (int w = 0; w < WAYS; w++) begin
               if (valid_r[set_of(st_addr_i)][w] &&
                   tag_mem[{set_of(st_addr_i), w[2:0]}] == tag_of(st_addr_i)) begin
                  dirty_r[set_of(st_addr_i)][w] <= 1'b1;
               end
            end
         end
         if (act_alloc || (act_pref && vic_dirty)) begin
            tag_mem[blk_idx]          <= tag_of(blk_addr);
            valid_r[eff_set][vic_way] <= act_alloc;
            dirty_r[eff_set][vic_way] <= 1'b0;
            lru_r[eff_set][2:0]       <= vic_way + 3'h1;
         end else if (act_pref && !hit) begin
            tag_mem[blk_idx]          <= tag_of(blk_addr);
            valid_r[eff_set][vic_way] <= 1'b0;
            dirty_r[eff_set][vic_way] <= 1'b0;
            lru_r[eff_set][2:0]       <= vic_way + 3'h1;
         end
         if (fill_pend_r && mem_req_o && !mem_wr_o && mem_ack_i) begin
            valid_r[set_of(fill_addr_r)][fill_way_r] <= 1'b1;
         end
      end
   end

   // ==================================================================
   // Result word
   // ==================================================================
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_valid_o <= 1'b0;
         result_o       <= 32'h0;
      end else begin
         result_valid_o <= go && (eff_op == DCSO_OP_RDTAG || eff_op == DCSO_OP_RDSTATUS);
         if (go && eff_op == DCSO_OP_RDTAG) begin
            result_o <= '0;
            result_o[`DCSO_RES_VALID] <= valid_r[eff_set][eff_addr[`DCSO_WAY_HI:`DCSO_WAY_LO]];
            result_o[20:0] <= tag_mem[{eff_set, eff_addr[`DCSO_WAY_HI:`DCSO_WAY_LO]}];
         end else if (go && eff_op == DCSO_OP_RDSTATUS) begin
            result_o <= '0;
            result_o[7:0] <= dirty_r[eff_set];
            result_o[`DCSO_RES_LRU_LO+9:`DCSO_RES_LRU_LO] <= lru_r[eff_set];
         end
      end
   end

   // ==================================================================
   // Special accesses and fixed load latency
   // ==================================================================
   wire cbinv_blocked = cbinv_i && mem_req_o && mem_wr_o &&
                        ((cbinv_addr_i & `DCSO_BLK_MASK) == wb_addr_r);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         access_stall_o <= 1'b0;
      end else if (special_req_i && !access_stall_o) begin
         access_stall_o <= 1'b1;
      end else if (special_done_i && !cbinv_blocked) begin
         access_stall_o <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ld_valid_pipe <= '0;
      end else begin
         ld_valid_pipe <= {ld_valid_pipe[`DCSO_LD_LAT-2:0], ld_valid_i};
      end
   end

   always_ff @(posedge core_clk_i) begin
      ld_data_pipe[0] <= ld_data_i;
      for (int i = 1; i < `DCSO_LD_LAT; i++) begin
         ld_data_pipe[i] <= ld_data_pipe[i-1];
      end
   end

   assign ld_valid_o = ld_valid_pipe[`DCSO_LD_LAT-1];
   assign ld_data_o  = ld_data_pipe[`DCSO_LD_LAT-1];

   // ==================================================================
   // Assertions
   // ==================================================================
   wire go_tag    = go && eff_op == DCSO_OP_RDTAG;
   wire go_status = go && eff_op == DCSO_OP_RDSTATUS;
   wire go_clean  = act_alloc && !vic_dirty;
   wire go_dirty  = (act_alloc || act_pref) && vic_dirty;

   property p_tag_no_stall;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      go_tag && !hold_now |=> result_valid_o && !cache_stall_o;
   endproperty
   a_tag_no_stall: assert property (p_tag_no_stall) else $error("tag read stalled");

   property p_status_one;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      go_status |=> cache_stall_o ##1 !cache_stall_o;
   endproperty
   a_status_one: assert property (p_status_one) else $error("status read stall not one cycle");

   property p_status_zero;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      go_status |=> result_o[31:18] == 14'h0000 && result_o[7:0] == $past(dirty_r[eff_set]);
   endproperty
   a_status_zero: assert property (p_status_zero) else $error("status word layout wrong");

   property p_alloc_clean;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      go_clean |=> cache_stall_o[*3] ##1 !cache_stall_o;
   endproperty
   a_alloc_clean: assert property (p_alloc_clean) else $error("clean allocate not three stalls");

   property p_dirty_min;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      go_dirty |=> cache_stall_o[*8] ##1 cache_stall_o[*3] ##0 (mem_req_o || wb_done_r);
   endproperty
   a_dirty_min: assert property (p_dirty_min) else $error("dirty victim stall under eleven");

   property p_alloc_discard;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      go && is_alloc && !cacheable && !fill_pend_r |=> !cache_stall_o && !mem_req_o;
   endproperty
   a_alloc_discard: assert property (p_alloc_discard) else $error("uncached allocate not discarded");

   property p_pref_drop;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      go && is_pref && pref_drop && !mem_req_o |=> !mem_req_o;
   endproperty
   a_pref_drop: assert property (p_pref_drop) else $error("prefetch not dropped");

   property p_pref_overlap;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      act_pref && !vic_dirty && !hit |=> mem_req_o && !mem_wr_o ##3 !cache_stall_o;
   endproperty
   a_pref_overlap: assert property (p_pref_overlap) else $error("prefetch fill not concurrent");

   property p_ld_lat;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      ld_valid_i |-> ##3 ld_valid_o && ld_data_o == $past(ld_data_i, 3);
   endproperty
   a_ld_lat: assert property (p_ld_lat) else $error("load latency not three");

   property p_special_stall;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      special_req_i && !access_stall_o |=> access_stall_o;
   endproperty
   a_special_stall: assert property (p_special_stall) else $error("special access did not stall");

   c_tag:    cover property (@(posedge core_clk_i) disable iff (!rst_n_i) go_tag);
   c_status: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) go_status);
   c_dirty:  cover property (@(posedge core_clk_i) disable iff (!rst_n_i) go_dirty);
   c_fill:   cover property (@(posedge core_clk_i) disable iff (!rst_n_i) fill_pend_r && mem_ack_i);

endmodule
